// file: debug_freeze_lowpower_ctrl.sv
// debug configuration register: watchdog freezes and low-power clock behaviour
// Behaviour
// - window watchdog frozen in debug when bit 9
// - independent watchdog frozen in debug when bit 8
// - standby debug: powered, clocks from internal rc
// - standby no debug: power down, clocks off
// - standby exit acts as reset, flags exit
// - stop debug: clocks from internal rc
// - stop no debug: all clocks gated off
// - stop exit restores reset clock, internal rc
// - sleep debug: both clocks on, source unchanged
// - sleep no debug: core on, bus off
// - sleep entry/exit keeps clock configuration
`timescale 1ns/1ps
module debug_freeze_lowpower_ctrl (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_i,
    input  wire debug_freeze_pkg::csr_req_t  csr_req_i,
    output logic [31:0]                      csr_rdata_o,
    input  wire logic                        debug_state_i,
    input  wire debug_freeze_pkg::pwr_mode_t mode_req_i,
    input  wire logic                        standby_flag_clr_i,
    output logic                             window_watchdog_freeze_o,
    output logic                             independent_watchdog_freeze_o,
    output debug_freeze_pkg::clk_pwr_t       clk_pwr_o,
    output logic                             clk_cfg_restore_o,
    output logic                             standby_exit_reset_o,
    output logic                             standby_exit_flag_o
);
    import debug_freeze_pkg::*;

    logic [31:0] debug_mcu_config;
    pwr_mode_t   mode;
    clk_pwr_t    next_clk_pwr;
    logic        csr_hit;
    logic        stop_exit;
    logic        standby_exit;

    assign csr_hit      = (csr_req_i.addr == DBG_CFG_CSR_ADDR);
    assign stop_exit    = (mode == PM_STOP) && (mode_req_i != PM_STOP);
    assign standby_exit = (mode == PM_STANDBY) && (mode_req_i != PM_STANDBY);

    // configuration register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            debug_mcu_config <= DBG_CFG_RESET;
        end else if (csr_req_i.we && csr_hit) begin
            debug_mcu_config <= csr_req_i.wdata & DBG_CFG_WMASK;
        end
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            csr_rdata_o <= CSR_RDATA_IDLE;
        end else if (csr_req_i.re && csr_hit) begin
            csr_rdata_o <= debug_mcu_config;
        end else begin
            csr_rdata_o <= CSR_RDATA_IDLE;
        end
    end

    // watchdog freezes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            window_watchdog_freeze_o      <= 1'b0;
            independent_watchdog_freeze_o <= 1'b0;
        end else begin
            window_watchdog_freeze_o      <= debug_mcu_config[WINDOW_WATCHDOG_FREEZE_BIT]
                                             & debug_state_i;
            independent_watchdog_freeze_o <= debug_mcu_config[INDEPENDENT_WATCHDOG_FREEZE_BIT]
                                             & debug_state_i;
        end
    end

    chk_independent_freeze_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !(debug_mcu_config[INDEPENDENT_WATCHDOG_FREEZE_BIT] && debug_state_i)
        |=> !independent_watchdog_freeze_o)
        else $error("independent watchdog frozen without cause");

    // power mode tracking
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode <= PM_RUN;
        end else begin
            mode <= mode_req_i;
        end
    end

    // clock and power per requested mode
    always_comb begin
        next_clk_pwr = clk_pwr_o;
        unique case (mode_req_i)
            PM_RUN: begin
                next_clk_pwr.core_clk_en      = 1'b1;
                next_clk_pwr.bus_clk_en       = 1'b1;
                next_clk_pwr.digital_power_on = 1'b1;
                // leaving stop falls back to the reset-default source
                if (stop_exit || standby_exit) begin
                    next_clk_pwr.clk_src = SRC_INTERNAL_RC;
                end
            end
            PM_SLEEP: begin
                // source left as configured so wake-up needs no setup
                next_clk_pwr.core_clk_en      = 1'b1;
                next_clk_pwr.bus_clk_en       = debug_mcu_config[SLEEP_DBG_BIT];
                next_clk_pwr.digital_power_on = 1'b1;
            end
            PM_STOP: begin
                next_clk_pwr.core_clk_en      = debug_mcu_config[STOP_DBG_BIT];
                next_clk_pwr.bus_clk_en       = debug_mcu_config[STOP_DBG_BIT];
                next_clk_pwr.clk_src          = SRC_INTERNAL_RC;
                next_clk_pwr.digital_power_on = 1'b1;
            end
            PM_STANDBY: begin
                next_clk_pwr.core_clk_en      = debug_mcu_config[STANDBY_DBG_BIT];
                next_clk_pwr.bus_clk_en       = debug_mcu_config[STANDBY_DBG_BIT];
                next_clk_pwr.clk_src          = SRC_INTERNAL_RC;
                next_clk_pwr.digital_power_on = debug_mcu_config[STANDBY_DBG_BIT];
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            clk_pwr_o <= CLK_PWR_RESET;
        end else begin
            clk_pwr_o <= next_clk_pwr;
        end
    end

    // exit events towards the clock controller and reset logic
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            clk_cfg_restore_o    <= 1'b0;
            standby_exit_reset_o <= 1'b0;
        end else begin
            // pll and crystal stay off until software re-enables them
            clk_cfg_restore_o    <= stop_exit || standby_exit;
            standby_exit_reset_o <= standby_exit;
        end
    end

    // sticky exit flag; a new exit beats a simultaneous clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            standby_exit_flag_o <= 1'b0;
        end else if (standby_exit) begin
            standby_exit_flag_o <= 1'b1;
        end else if (standby_flag_clr_i) begin
            standby_exit_flag_o <= 1'b0;
        end
    end

    chk_exit_flag_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
        standby_exit_flag_o && !standby_flag_clr_i |=> standby_exit_flag_o)
        else $error("standby exit flag lost");

    chk_exit_beats_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        standby_exit |=> standby_exit_flag_o)
        else $error("standby exit flag not set");

    chk_window_freeze_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
        window_watchdog_freeze_o == ($past(debug_mcu_config[WINDOW_WATCHDOG_FREEZE_BIT])
                                     && $past(debug_state_i)))
        else $error("window watchdog freeze wrong");

    chk_independent_freeze_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (debug_mcu_config[INDEPENDENT_WATCHDOG_FREEZE_BIT] && debug_state_i)
        |=> independent_watchdog_freeze_o)
        else $error("independent watchdog not frozen");

    chk_freeze_needs_debug: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !debug_state_i |=> !window_watchdog_freeze_o && !independent_watchdog_freeze_o)
        else $error("freeze outside debug state");

    chk_standby_debug_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STANDBY && debug_mcu_config[STANDBY_DBG_BIT])
        |=> clk_pwr_o.digital_power_on && clk_pwr_o.core_clk_en
            && clk_pwr_o.clk_src == SRC_INTERNAL_RC)
        else $error("standby debug clocks wrong");

    chk_standby_power_down: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STANDBY && !debug_mcu_config[STANDBY_DBG_BIT])
        |=> !clk_pwr_o.digital_power_on && !clk_pwr_o.core_clk_en && !clk_pwr_o.bus_clk_en)
        else $error("standby not powered down");

    chk_standby_exit_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(mode == PM_STANDBY) |-> standby_exit_reset_o && standby_exit_flag_o
                                      ##1 !standby_exit_reset_o)
        else $error("standby exit not signalled");

    chk_stop_clocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STOP) |=> clk_pwr_o.core_clk_en == $past(debug_mcu_config[STOP_DBG_BIT])
                                    && clk_pwr_o.bus_clk_en == clk_pwr_o.core_clk_en)
        else $error("stop clocks wrong");

    chk_stop_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STOP && !debug_mcu_config[STOP_DBG_BIT])
        |=> !clk_pwr_o.core_clk_en && !clk_pwr_o.bus_clk_en)
        else $error("stop clocks not gated");

    chk_stop_exit_restore: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == PM_STOP && mode_req_i == PM_RUN)
        |=> clk_cfg_restore_o && clk_pwr_o.clk_src == SRC_INTERNAL_RC)
        else $error("stop exit restore missing");

    chk_sleep_bus_clock: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_SLEEP) |=> clk_pwr_o.core_clk_en
            && clk_pwr_o.bus_clk_en == $past(debug_mcu_config[SLEEP_DBG_BIT]))
        else $error("sleep clocks wrong");

    chk_sleep_keeps_src: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == PM_SLEEP || mode_req_i == PM_SLEEP) && mode != PM_STOP && mode != PM_STANDBY
        |=> $stable(clk_pwr_o.clk_src) && !clk_cfg_restore_o)
        else $error("sleep changed clock source");

    chk_stop_debug_clocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STOP && debug_mcu_config[STOP_DBG_BIT])
        |=> clk_pwr_o.core_clk_en && clk_pwr_o.bus_clk_en && clk_pwr_o.clk_src == SRC_INTERNAL_RC)
        else $error("stop debug clocks wrong");

    chk_standby_bus_clock: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode_req_i == PM_STANDBY && debug_mcu_config[STANDBY_DBG_BIT])
        |=> clk_pwr_o.bus_clk_en)
        else $error("standby debug bus clock off");

    chk_standby_exit_src: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == PM_STANDBY && mode_req_i == PM_RUN)
        |=> clk_cfg_restore_o && clk_pwr_o.clk_src == SRC_INTERNAL_RC)
        else $error("standby exit restore missing");

endmodule : debug_freeze_lowpower_ctrl

// file: debug_freeze_lowpower_ctrl_tb.sv
// self-checking testbench for the debug freeze and low-power clock control block
`timescale 1ns/1ps
module debug_freeze_lowpower_ctrl_tb;
    import debug_freeze_pkg::*;

    logic        core_clk_i;
    logic        rst_i;
    csr_req_t    csr_req_i;
    logic [31:0] csr_rdata_o;
    logic        debug_state_i;
    pwr_mode_t   mode_req_i;
    logic        standby_flag_clr_i;
    logic        window_watchdog_freeze_o;
    logic        independent_watchdog_freeze_o;
    clk_pwr_t    clk_pwr_o;
    logic        clk_cfg_restore_o;
    logic        standby_exit_reset_o;
    logic        standby_exit_flag_o;
    int          n_fail;
    int          n_checks;
    logic [31:0] cfg;
    logic [31:0] d;
    logic        sflag;

    debug_freeze_lowpower_ctrl i_dut (
        .core_clk_i, .rst_i, .csr_req_i, .csr_rdata_o, .debug_state_i, .mode_req_i,
        .standby_flag_clr_i, .window_watchdog_freeze_o, .independent_watchdog_freeze_o,
        .clk_pwr_o, .clk_cfg_restore_o, .standby_exit_reset_o, .standby_exit_flag_o
    );

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // expected clock and power controls for a requested mode
    function automatic clk_pwr_t exp_pwr(input pwr_mode_t m, input logic [31:0] c);
        clk_pwr_t e;
        e = CLK_PWR_RESET;
        case (m)
            PM_SLEEP:   e.bus_clk_en = c[SLEEP_DBG_BIT];
            PM_STOP:    if (!c[STOP_DBG_BIT]) {e.core_clk_en, e.bus_clk_en} = 2'b00;
            PM_STANDBY: if (!c[STANDBY_DBG_BIT]) e = '{1'b0, 1'b0, SRC_INTERNAL_RC, 1'b0};
            default:    e = CLK_PWR_RESET;
        endcase
        return e;
    endfunction : exp_pwr

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // request held across exactly one sampling edge, then dropped
    task automatic csr_op(input logic [11:0] a, input logic we, input logic [31:0] wd);
        @(posedge core_clk_i);
        csr_req_i <= '{addr: a, we: we, re: !we, wdata: wd};
        @(posedge core_clk_i);
        csr_req_i <= '0;
        #1;
    endtask : csr_op

    task automatic do_reset(input int n);
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        check(32'(clk_pwr_o), 32'(CLK_PWR_RESET), "reset clocks");
        check(32'(standby_exit_flag_o), 32'h0, "reset flag");
        csr_op(DBG_CFG_CSR_ADDR, 1'b0, 32'h0);
        check(csr_rdata_o, DBG_CFG_RESET, "reset config");
        cfg = DBG_CFG_RESET;
        sflag = 1'b0;
    endtask : do_reset

    task automatic mode_run(input pwr_mode_t m, input logic clr);
        @(posedge core_clk_i);
        mode_req_i <= m;
        debug_state_i <= 1'($urandom);
        @(posedge core_clk_i);
        mode_req_i <= PM_RUN;
        standby_flag_clr_i <= clr;
        #1;
        check(32'(clk_pwr_o), 32'(exp_pwr(m, cfg)), "mode clocks");
        @(posedge core_clk_i);
        standby_flag_clr_i <= 1'b0;
        #1;
        // exit sets the flag even when a clear arrives in the same cycle
        sflag = (m == PM_STANDBY) ? 1'b1 : (clr ? 1'b0 : sflag);
        check(32'(clk_pwr_o), 32'(CLK_PWR_RESET), "wake clocks");
        check(32'(clk_cfg_restore_o), 32'(m != PM_SLEEP), "restore pulse");
        check(32'(standby_exit_reset_o), 32'(m == PM_STANDBY), "exit reset");
        check(32'(standby_exit_flag_o), 32'(sflag), "exit flag");
        @(posedge core_clk_i);
        #1;
        check(32'({clk_cfg_restore_o, standby_exit_reset_o}), 32'h0, "pulse width");
    endtask : mode_run

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        final_report();
    end

    initial begin
        rst_i = 1'b1;
        csr_req_i = '0;
        debug_state_i = 1'b0;
        mode_req_i = PM_RUN;
        standby_flag_clr_i = 1'b0;
        n_fail = 0;
        n_checks = 0;
        void'($urandom(14));
        do_reset(10);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 32'hffff_ffff : $urandom;
            csr_op(DBG_CFG_CSR_ADDR, 1'b1, d);
            csr_op(DBG_CFG_CSR_ADDR ^ 12'h001, 1'b1, ~d);
            csr_op(DBG_CFG_CSR_ADDR, 1'b0, 32'h0);
            check(csr_rdata_o, d & DBG_CFG_WMASK, "config read");
            csr_op(DBG_CFG_CSR_ADDR ^ 12'h001, 1'b0, 32'h0);
            check(csr_rdata_o, CSR_RDATA_IDLE, "unmapped read");
        end
        $display("test register done");
        for (int k = 0; k < 16; k++) begin
            cfg = (k < 4) ? 32'(k) << 8 : $urandom & DBG_CFG_WMASK;
            csr_op(DBG_CFG_CSR_ADDR, 1'b1, cfg);
            for (int j = 0; j < 4; j++) begin
                @(posedge core_clk_i);
                debug_state_i <= 1'($urandom);
                @(posedge core_clk_i);
                #1;
                check(32'(window_watchdog_freeze_o), 32'(cfg[9] & debug_state_i), "ww");
                check(32'(independent_watchdog_freeze_o), 32'(cfg[8] & debug_state_i), "iw");
            end
        end
        $display("test freeze done");
        for (int c = 0; c < 8; c++) begin
            cfg = 32'(c) | ($urandom & 32'h0000_0300);
            csr_op(DBG_CFG_CSR_ADDR, 1'b1, cfg);
            for (int m = 1; m < 4; m++) begin
                mode_run(pwr_mode_t'(m), 1'($urandom));
            end
        end
        $display("test modes done");
        do_reset(2);
        mode_run(PM_STANDBY, 1'b1);
        $display("test second reset done");
        final_report();
    end
endmodule : debug_freeze_lowpower_ctrl_tb

// file: debug_freeze_pkg.sv
// constants and types for the debug freeze and low-power clock control block
package debug_freeze_pkg;

    // configuration register, reached through the core's csr port
    localparam logic [11:0] DBG_CFG_CSR_ADDR = 12'h7c0;
    localparam logic [31:0] DBG_CFG_RESET    = 32'h0000_0000;
    // writable bits of the lower half handled here; the rest read as zero
    localparam logic [31:0] DBG_CFG_WMASK    = 32'h0000_0307;
    localparam logic [31:0] CSR_RDATA_IDLE   = 32'h0000_0000;

    localparam int WINDOW_WATCHDOG_FREEZE_BIT      = 9;
    localparam int INDEPENDENT_WATCHDOG_FREEZE_BIT = 8;
    localparam int STANDBY_DBG_BIT                 = 2;
    localparam int STOP_DBG_BIT                    = 1;
    localparam int SLEEP_DBG_BIT                   = 0;

    // frequency of the reset-default clock source after a stop exit
    localparam int INTERNAL_RC_OSC_8M_MHZ = 8;

    typedef enum logic [1:0] {
        PM_RUN     = 2'b00,
        PM_SLEEP   = 2'b01,
        PM_STOP    = 2'b10,
        PM_STANDBY = 2'b11
    } pwr_mode_t;

    typedef enum logic {
        SRC_SYSCLK      = 1'b0,
        SRC_INTERNAL_RC = 1'b1
    } clk_src_t;

    typedef struct packed {
        logic     core_clk_en;
        logic     bus_clk_en;
        clk_src_t clk_src;
        logic     digital_power_on;
    } clk_pwr_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        we;
        logic        re;
        logic [31:0] wdata;
    } csr_req_t;

    localparam clk_pwr_t CLK_PWR_RESET = '{
        core_clk_en:      1'b1,
        bus_clk_en:       1'b1,
        clk_src:          SRC_INTERNAL_RC,
        digital_power_on: 1'b1
    };

endpackage : debug_freeze_pkg
